// ---- design/ledpw_top.sv ----
// I2C register target and duty register bank of the 36-channel LED driver
`timescale 1ns/1ps
`include "ledpw_defines.svh"
module ledpw_top import ledpw_pkg::*; (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_addr_strap,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic [35:0] o_led,
  output logic o_soft_shutdown_n,
  output logic [7:0] o_green_current_level,
  output logic [7:0] o_red_current_level,
  output logic [7:0] o_blue_current_level,
  output logic [7:0] o_phase_cfg
);
  localparam int T_LOW_CYC = `LEDPW_T_LOW_CYC;
  ledpw_state_t state_reg, state_next;
  logic scl_meta_reg, scl_reg, scl_prev_reg;
  logic sda_meta_reg, sda_reg, sda_prev_reg;
  logic strap_meta_reg, strap_reg;
  logic [1:0] strap_lo_reg;
  logic [7:0] shift_reg, tx_reg, ptr_reg;
  logic [3:0] bits_reg;
  logic rw_reg, nack_reg;
  logic [7:0] ctrl_reg, green_group_current_reg, red_group_current_reg, blue_group_current_reg, phase_reg;
  logic [7:0] hf_pend [`LEDPW_HF_BYTES];
  logic [7:0] hf_act [`LEDPW_HF_BYTES];
  logic [7:0] lf_pend [`LEDPW_CHANNELS];
  logic [7:0] lf_act [`LEDPW_CHANNELS];
  logic [359:0] fast_duty;
  logic [287:0] slow_duty;
  logic [71:0] drive_mode;
  logic [15:0] osc_step;

  // Index of the fast duty low byte used by a channel
  function automatic int pair_base(input int c, input logic grouped);
    return grouped ? 2 * (c / `LEDPW_GROUP_SIZE) : 2 * c;
  endfunction : pair_base

  // Two flops per pin, then a prev stage for edges; fine to 1MHz
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      {scl_meta_reg, scl_reg, scl_prev_reg} <= 3'h7;
      {sda_meta_reg, sda_reg, sda_prev_reg} <= 3'h7;
      {strap_meta_reg, strap_reg} <= 2'h0;
    end else begin
      {scl_meta_reg, scl_reg, scl_prev_reg} <= {i_scl, scl_meta_reg, scl_reg};
      {sda_meta_reg, sda_reg, sda_prev_reg} <= {i_sda, sda_meta_reg, sda_reg};
      {strap_meta_reg, strap_reg} <= {i_addr_strap, strap_meta_reg};
    end
  end

  // Bus events
  wire scl_rise = scl_reg & ~scl_prev_reg;
  wire scl_fall = ~scl_reg & scl_prev_reg;
  wire start_evt = scl_reg & scl_prev_reg & sda_prev_reg
                   & ~sda_reg;
  wire stop_evt = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;
  wire byte_done = scl_fall & (bits_reg == `LEDPW_BYTE_BITS);
  wire addr_match =
    shift_reg[7:1] == {`LEDPW_ADDR_FIXED, strap_lo_reg};

  // Strap seen when SCL and SDA differ tells which net it follows
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      strap_lo_reg <= 2'h0;
    end else begin
      if (scl_reg & ~sda_reg) strap_lo_reg[0] <= strap_reg;
      if (~scl_reg & sda_reg) strap_lo_reg[1] <= strap_reg;
    end
  end

  // Register address decode on the pointer
  wire in_hf = ptr_reg >= `LEDPW_REG_HF_FIRST && ptr_reg <= `LEDPW_REG_HF_LAST;
  wire in_lf = ptr_reg >= `LEDPW_REG_LF_FIRST && ptr_reg <= `LEDPW_REG_LF_LAST;
  wire [6:0] hf_idx = 7'(ptr_reg - `LEDPW_REG_HF_FIRST);
  wire [5:0] lf_idx = 6'(ptr_reg - `LEDPW_REG_LF_FIRST);
  wire wr_strobe = (state_reg == LEDPW_WDATA) & byte_done;
  wire wr_ctrl = wr_strobe & (ptr_reg == `LEDPW_REG_CTRL);
  wire wr_hf = wr_strobe & in_hf;
  wire wr_lf = wr_strobe & in_lf;
  wire wr_update = wr_strobe & (ptr_reg == `LEDPW_REG_UPDATE);
  wire wr_reset = wr_strobe & (ptr_reg == `LEDPW_REG_RESET);
  wire clear_all = i_rst | wr_reset;
  wire [7:0] hf_wdata = hf_idx[0] ? (shift_reg & `LEDPW_HFH_MASK) : shift_reg;
  wire rd_load = (state_reg == LEDPW_ADDR_ACK && rw_reg && scl_fall) ||
                 (state_reg == LEDPW_RDATA_ACK && scl_fall && !nack_reg);

  // Read mux; write-only and unmapped addresses read zero
  wire [7:0] rd_byte =
    (ptr_reg == `LEDPW_REG_CTRL) ? ctrl_reg :
    in_hf ? hf_pend[hf_idx] :
    in_lf ? lf_pend[lf_idx] :
    (ptr_reg == `LEDPW_REG_GREEN_GROUP_CURRENT) ? green_group_current_reg :
    (ptr_reg == `LEDPW_REG_RED_GROUP_CURRENT) ? red_group_current_reg :
    (ptr_reg == `LEDPW_REG_BLUE_GROUP_CURRENT) ? blue_group_current_reg :
    (ptr_reg == `LEDPW_REG_PHASE) ? phase_reg : `LEDPW_RST_BYTE;

  // Next state of the bus engine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LEDPW_IDLE: state_next = LEDPW_IDLE;
      LEDPW_ADDR: if (byte_done) begin
        state_next = addr_match ? LEDPW_ADDR_ACK : LEDPW_IDLE;
      end
      LEDPW_ADDR_ACK: if (scl_fall) begin
        state_next = rw_reg ? LEDPW_RDATA : LEDPW_PTR;
      end
      LEDPW_PTR: if (byte_done) state_next = LEDPW_PTR_ACK;
      LEDPW_PTR_ACK: if (scl_fall) state_next = LEDPW_WDATA;
      LEDPW_WDATA: if (byte_done) state_next = LEDPW_WDATA_ACK;
      LEDPW_WDATA_ACK: if (scl_fall) state_next = LEDPW_WDATA;
      LEDPW_RDATA: if (byte_done) state_next = LEDPW_RDATA_ACK;
      LEDPW_RDATA_ACK: if (scl_fall) begin
        state_next = nack_reg ? LEDPW_IDLE : LEDPW_RDATA;
      end
    endcase
    // A START restarts address compare from any state
    if (start_evt) state_next = LEDPW_ADDR;
    else if (stop_evt) state_next = LEDPW_IDLE;
  end

  // SDA pulled low only for acks and zero read bits
  wire ack_next = state_next inside {LEDPW_ADDR_ACK, LEDPW_PTR_ACK,
                                     LEDPW_WDATA_ACK};
  wire [7:0] tx_next = rd_load ? rd_byte :
                       (state_reg == LEDPW_RDATA && scl_fall) ?
                       {tx_reg[6:0], 1'b1} : tx_reg;
  wire drive_low = ack_next |
                   (state_next == LEDPW_RDATA && !tx_next[7]);

  // Bus engine registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= LEDPW_IDLE;
      shift_reg <= 8'h00;
      tx_reg <= 8'hff;
      bits_reg <= 4'h0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      o_sda_oe_n <= 1'b1;
      o_sda_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      tx_reg <= tx_next;
      o_sda_oe_n <= ~drive_low;
      o_sda_out <= 1'b0;
      // Data taken on the rising SCL edge, MSB first
      if (scl_rise) begin
        shift_reg <= {shift_reg[6:0], sda_reg};
        bits_reg <= 4'(bits_reg + 4'h1);
      end
      if (start_evt || (scl_fall && state_reg inside
          {LEDPW_ADDR_ACK, LEDPW_PTR_ACK, LEDPW_WDATA_ACK,
           LEDPW_RDATA_ACK})) begin
        bits_reg <= 4'h0;
      end
      if (state_reg == LEDPW_ADDR && byte_done) rw_reg <= shift_reg[0];
      if (state_reg == LEDPW_RDATA_ACK && scl_rise) nack_reg <= sda_reg;
    end
  end

  // Pointer loads from the pointer byte and steps per data byte
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ptr_reg <= 8'h00;
    end else if (state_reg == LEDPW_PTR && byte_done) begin
      ptr_reg <= shift_reg;
    end else if (wr_strobe || rd_load) begin
      ptr_reg <= 8'(ptr_reg + `LEDPW_PTR_STEP);
    end
  end

  // Scalar registers; reserved bits are kept at zero
  always_ff @(posedge i_clock) begin
    if (clear_all) begin
      ctrl_reg <= `LEDPW_RST_BYTE;
      green_group_current_reg <= `LEDPW_RST_BYTE;
      red_group_current_reg <= `LEDPW_RST_BYTE;
      blue_group_current_reg <= `LEDPW_RST_BYTE;
      phase_reg <= `LEDPW_RST_BYTE;
    end else if (wr_strobe) begin
      if (wr_ctrl) ctrl_reg <= shift_reg & `LEDPW_CTRL_MASK;
      if (ptr_reg == `LEDPW_REG_GREEN_GROUP_CURRENT) green_group_current_reg <= shift_reg;
      if (ptr_reg == `LEDPW_REG_RED_GROUP_CURRENT) red_group_current_reg <= shift_reg;
      if (ptr_reg == `LEDPW_REG_BLUE_GROUP_CURRENT) blue_group_current_reg <= shift_reg;
      if (ptr_reg == `LEDPW_REG_PHASE) phase_reg <= shift_reg;
    end
  end

  // Pending duty banks, written over the bus
  always_ff @(posedge i_clock) begin
    if (clear_all) begin
      for (int i = 0; i < `LEDPW_HF_BYTES; i++) hf_pend[i] <= `LEDPW_RST_BYTE;
      for (int i = 0; i < `LEDPW_CHANNELS; i++) lf_pend[i] <= `LEDPW_RST_BYTE;
    end else begin
      if (wr_hf) hf_pend[hf_idx] <= hf_wdata;
      if (wr_lf) lf_pend[lf_idx] <= shift_reg;
    end
  end

  // Active banks change only on an update write or a reset, so a multi-byte
  // colour change lands on the outputs in one step
  always_ff @(posedge i_clock) begin
    if (clear_all) begin
      for (int i = 0; i < `LEDPW_HF_BYTES; i++) hf_act[i] <= `LEDPW_RST_BYTE;
      for (int i = 0; i < `LEDPW_CHANNELS; i++) lf_act[i] <= `LEDPW_RST_BYTE;
    end else if (wr_update) begin
      hf_act <= hf_pend;
      lf_act <= lf_pend;
    end
  end

  // Channel view of the active banks, with optional triple sharing of the fast duty pairs
  always_comb begin
    int b;
    b = 0;
    for (int c = 0; c < `LEDPW_CHANNELS; c++) begin
      b = pair_base(c, ctrl_reg[`LEDPW_CTRL_GROUP]);
      fast_duty[10*c +: 10] = ctrl_reg[`LEDPW_CTRL_PMS] ?
        {hf_act[b+1][`LEDPW_HFH_EXT], hf_act[b]} :
        {2'h0, hf_act[b]};
      drive_mode[2*c +: 2] = hf_act[b+1][`LEDPW_HFH_MODE];
      slow_duty[8*c +: 8] = lf_act[c];
    end
  end

  // Oscillator rate: ten-bit ignores the rate field
  assign osc_step =
    ctrl_reg[`LEDPW_CTRL_PMS] ? `LEDPW_NCO_STEP(32) :
    (ctrl_reg[`LEDPW_CTRL_RATE] == `LEDPW_RATE_8M) ? `LEDPW_NCO_STEP(8) :
    (ctrl_reg[`LEDPW_CTRL_RATE] == `LEDPW_RATE_16M) ? `LEDPW_NCO_STEP(16) :
    `LEDPW_NCO_STEP(32);

  ledpw_pwm_core u_pwm (
    .i_clock(i_clock),
    .i_rst(clear_all),
    .i_run(ctrl_reg[`LEDPW_CTRL_SSD]),
    .i_hi_res(ctrl_reg[`LEDPW_CTRL_PMS]),
    .i_osc_step(osc_step),
    .i_fast_duty(fast_duty),
    .i_slow_duty(slow_duty),
    .i_drive_mode(drive_mode),
    .o_led(o_led)
  );

  // Analog-facing copies, registered
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_soft_shutdown_n <= 1'b0;
      o_green_current_level <= `LEDPW_RST_BYTE;
      o_red_current_level <= `LEDPW_RST_BYTE;
      o_blue_current_level <= `LEDPW_RST_BYTE;
      o_phase_cfg <= `LEDPW_RST_BYTE;
    end else begin
      o_soft_shutdown_n <= ctrl_reg[`LEDPW_CTRL_SSD];
      o_green_current_level <= green_group_current_reg;
      o_red_current_level <= red_group_current_reg;
      o_blue_current_level <= blue_group_current_reg;
      o_phase_cfg <= phase_reg;
    end
  end

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  start_addr_a: assert property (
    start_evt |=> state_reg == LEDPW_ADDR && o_sda_oe_n)
    else $error("START did not restart address");
  stop_idle_a: assert property (
    stop_evt |=> state_reg == LEDPW_IDLE)
    else $error("STOP did not end transfer");
  addr_ack_a: assert property (
    state_reg == LEDPW_ADDR && byte_done && addr_match
    |=> !o_sda_oe_n ##0 state_reg == LEDPW_ADDR_ACK)
    else $error("own address not acknowledged");
  addr_miss_a: assert property (
    state_reg == LEDPW_ADDR && byte_done && !addr_match
    |=> o_sda_oe_n [*2])
    else $error("foreign address acknowledged");
  ptr_ack_a: assert property (
    state_reg == LEDPW_PTR && byte_done
    |=> !o_sda_oe_n && ptr_reg == $past(shift_reg))
    else $error("pointer byte not taken");
  data_ack_a: assert property (
    wr_strobe |=> !o_sda_oe_n && state_reg == LEDPW_WDATA_ACK)
    else $error("data byte not acknowledged");
  ptr_step_a: assert property (
    wr_strobe |=> ptr_reg == 8'($past(ptr_reg) + `LEDPW_PTR_STEP))
    else $error("pointer did not step");
  ack_timely_a: assert property (
    state_reg == LEDPW_ADDR && byte_done && addr_match
    |-> ##[1:T_LOW_CYC] !o_sda_oe_n)
    else $error("acknowledge later than the clock low phase");
  ack_release_a: assert property (
    scl_fall && state_reg inside {LEDPW_PTR_ACK, LEDPW_WDATA_ACK}
    |=> o_sda_oe_n)
    else $error("data line held after acknowledge");
  // Main scenarios: update, read load, restore, repeated start
  update_seen_c: cover property (wr_update);
  read_seen_c: cover property (rd_load);
  restore_seen_c: cover property (wr_reset);
  restart_seen_c: cover property (start_evt && state_reg == LEDPW_WDATA);
endmodule : ledpw_top

// ---- design/ledpw_defines.svh ----
// Register map, field positions and timing counts of the LED PWM target
`ifndef LEDPW_DEFINES_SVH
`define LEDPW_DEFINES_SVH
`define LEDPW_ADDR_FIXED 5'h0c
`define LEDPW_REG_CTRL 8'h00
`define LEDPW_REG_HF_FIRST 8'h01
`define LEDPW_REG_HF_LAST 8'h48
`define LEDPW_REG_LF_FIRST 8'h49
`define LEDPW_REG_LF_LAST 8'h6c
`define LEDPW_REG_UPDATE 8'h6d
`define LEDPW_REG_GREEN_GROUP_CURRENT 8'h6e
`define LEDPW_REG_RED_GROUP_CURRENT 8'h6f
`define LEDPW_REG_BLUE_GROUP_CURRENT 8'h70
`define LEDPW_REG_PHASE 8'h71
`define LEDPW_REG_RESET 8'h7f
`define LEDPW_RST_BYTE 8'h00
`define LEDPW_PTR_STEP 8'h01
`define LEDPW_CTRL_SSD 0
`define LEDPW_CTRL_PMS 1
`define LEDPW_CTRL_RATE 5:4
`define LEDPW_CTRL_GROUP 6
`define LEDPW_CTRL_MASK 8'h73
`define LEDPW_HFH_MASK 8'h0f
`define LEDPW_HFH_EXT 1:0
`define LEDPW_HFH_MODE 3:2
`define LEDPW_CHANNELS 36
`define LEDPW_HF_BYTES 72
`define LEDPW_GROUP_SIZE 3
`define LEDPW_BYTE_BITS 4'h8
`define LEDPW_FM_MIX 2'h0
`define LEDPW_FM_FAST 2'h1
`define LEDPW_FM_DC 2'h2
`define LEDPW_FM_OFF 2'h3
`define LEDPW_RATE_8M 2'h0
`define LEDPW_RATE_16M 2'h1
`define LEDPW_HF8_TOP 10'h0ff
`define LEDPW_HF10_TOP 10'h3ff
`define LEDPW_CLK_MHZ 100
`define LEDPW_NCO_STEP(mhz) (16'((mhz) * 65536 / `LEDPW_CLK_MHZ))
`define LEDPW_CLK_NS 10
`define LEDPW_SCL_MAX_KHZ 1000
`define LEDPW_T_LOW_NS 500
`define LEDPW_T_LOW_CYC ((`LEDPW_T_LOW_NS + `LEDPW_CLK_NS - 1) / `LEDPW_CLK_NS)
`endif

// ---- design/ledpw_pkg.sv ----
// Types shared by the LED PWM target
package ledpw_pkg;
  typedef enum logic [3:0] {
    LEDPW_IDLE, LEDPW_ADDR, LEDPW_ADDR_ACK, LEDPW_PTR, LEDPW_PTR_ACK,
    LEDPW_WDATA, LEDPW_WDATA_ACK, LEDPW_RDATA, LEDPW_RDATA_ACK
  } ledpw_state_t;
endpackage : ledpw_pkg

// ---- design/ledpw_pwm_core.sv ----
// Two-level PWM engine driving the 36 LED channel enables
`timescale 1ns/1ps
`include "ledpw_defines.svh"
module ledpw_pwm_core import ledpw_pkg::*; (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic i_hi_res,
  input wire logic [15:0] i_osc_step,
  input wire logic [359:0] i_fast_duty,
  input wire logic [287:0] i_slow_duty,
  input wire logic [71:0] i_drive_mode,
  output logic [35:0] o_led
);
  logic [15:0] acc_reg;
  logic [9:0] fast_reg;
  logic [7:0] slow_reg;
  logic [35:0] led_next;
  logic [16:0] acc_sum;
  logic tick;
  logic fast_wrap;
  logic [9:0] fast_top;

  // Channel level from its drive mode and both comparisons
  function automatic logic chan_on(input logic [1:0] mode,
                                   input logic f_on, input logic s_on);
    logic r;
    r = 1'b0;
    unique case (mode)
      `LEDPW_FM_MIX: r = f_on & s_on;
      `LEDPW_FM_FAST: r = f_on;
      `LEDPW_FM_DC: r = 1'b1;
      `LEDPW_FM_OFF: r = 1'b0;
    endcase
    return r;
  endfunction : chan_on

  // Oscillator emulated by a phase accumulator; tick is its carry
  assign acc_sum = {1'b0, acc_reg} + {1'b0, i_osc_step};
  assign tick = acc_sum[16];
  assign fast_top = i_hi_res ? `LEDPW_HF10_TOP : `LEDPW_HF8_TOP;
  // >= so a drop from 10-bit to 8-bit cannot strand the counter
  assign fast_wrap = tick & (fast_reg >= fast_top);

  // One slow step per full fast period
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      acc_reg <= 16'h0000;
      fast_reg <= 10'h000;
      slow_reg <= 8'h00;
    end else begin
      acc_reg <= acc_sum[15:0];
      if (tick) fast_reg <= fast_wrap ? 10'h000 : 10'(fast_reg + 10'h001);
      if (fast_wrap) slow_reg <= 8'(slow_reg + 8'h01);
    end
  end

  // Per-channel compare; shutdown forces all off
  always_comb begin
    for (int c = 0; c < `LEDPW_CHANNELS; c++) begin
      led_next[c] = i_run & chan_on(i_drive_mode[2*c +: 2],
                    fast_reg < i_fast_duty[10*c +: 10],
                    slow_reg < i_slow_duty[8*c +: 8]);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) o_led <= 36'h0;
    else o_led <= led_next;
  end
endmodule : ledpw_pwm_core

// ---- verif/ledpw_host_model.sv ----
// Behavioural I2C bus controller that talks to the LED target
`timescale 1ns/1ps
module ledpw_host_model (
  input wire logic i_clock,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // Both lines idle high; data low means pulling the wire down
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task hold(input int n);
    repeat (n) @(negedge i_clock);
  endtask : hold
  // Data moves only while the clock is low, 160 ns a bit
  task put_bit(input logic b);
    o_sda = b;
    hold(4);
    o_scl = 1'b1;
    hold(8);
    o_scl = 1'b0;
    hold(4);
  endtask : put_bit
  // Line released so the target can answer; sampled mid-high
  task get_bit(output logic b);
    o_sda = 1'b1;
    hold(4);
    o_scl = 1'b1;
    hold(4);
    b = i_sda;
    hold(4);
    o_scl = 1'b0;
    hold(4);
  endtask : get_bit
  // Start or repeated start: data falls with clock high
  task start;
    o_sda = 1'b1;
    hold(4);
    o_scl = 1'b1;
    hold(8);
    o_sda = 1'b0;
    hold(8);
    o_scl = 1'b0;
    hold(4);
  endtask : start
  // Stop: data rises with clock high, then bus free time
  task stop;
    o_sda = 1'b0;
    hold(4);
    o_scl = 1'b1;
    hold(8);
    o_sda = 1'b1;
    hold(50);
  endtask : stop
  // Byte out MSB first, then the acknowledge slot
  task send(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(b);
    ack = ~b;
  endtask : send
  // Byte in MSB first; last byte is not acknowledged
  task recv(output logic [7:0] v, input logic last);
    for (int i = 7; i >= 0; i--) get_bit(v[i]);
    put_bit(last);
  endtask : recv
endmodule : ledpw_host_model

// ---- verif/test_led_driver_i2c_register_pwm_ctrl.sv ----
// Self-checking bench for the I2C register target of the LED driver
`timescale 1ns/1ps
module test_led_driver_i2c_register_pwm_ctrl import ledpw_pkg::*;;
  logic i_clock;
  logic i_rst;
  logic scl, host_sda, sda_w, strap, sda_out, sda_oe_n, shdn_n;
  logic [1:0] strap_sel;
  logic [35:0] led;
  logic [7:0] cur_g, cur_r, cur_b, phase;
  logic [6:0] dev;
  integer seed;
  int fail_count = 0;
  int compares = 0;
  always #5 i_clock = ~i_clock;
  // Open-drain wire: low whenever either party pulls down
  assign sda_w = host_sda & (sda_oe_n | sda_out);
  // Strap pin wired to ground, supply, clock line or data line
  assign strap = (strap_sel == 2'h0) ? 1'b0 : (strap_sel == 2'h1) ? 1'b1 :
                 (strap_sel == 2'h2) ? scl : sda_w;
  ledpw_top DUT (.i_clock(i_clock), .i_rst(i_rst), .i_scl(scl),
    .i_sda(sda_w), .i_addr_strap(strap), .o_sda_out(sda_out),
    .o_sda_oe_n(sda_oe_n), .o_led(led), .o_soft_shutdown_n(shdn_n),
    .o_green_current_level(cur_g), .o_red_current_level(cur_r),
    .o_blue_current_level(cur_b), .o_phase_cfg(phase));
  ledpw_host_model host (.i_clock(i_clock), .i_sda(sda_w), .o_scl(scl),
    .o_sda(host_sda));
  // Low address bits expected for each strap connection
  function logic [1:0] strap_bits(input logic [1:0] s);
    return (s == 2'h0) ? 2'h0 : (s == 2'h1) ? 2'h3 : (s == 2'h2) ? 2'h1 : 2'h2;
  endfunction : strap_bits
  task check8(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : check8
  task check1(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %b want %b", $time, m, got, exp);
    end
  endtask : check1
  // Write n bytes from the top of d, starting at pointer p
  task wr(input logic [7:0] p, input int n, input logic [31:0] d);
    logic k;
    host.start();
    host.send({dev, 1'b0}, k);
    check1(k, 1'b1, "address ack");
    host.send(p, k);
    check1(k, 1'b1, "pointer ack");
    for (int i = 0; i < n; i++) begin
      host.send(d[31 - 8 * i -: 8], k);
      check1(k, 1'b1, "data ack");
    end
    host.stop();
    check1(sda_oe_n, 1'b1, "data line released");
  endtask : wr
  // Pointer write, repeated start, one byte read back
  task rd(input logic [7:0] p, input logic [7:0] exp);
    logic k;
    logic [7:0] v;
    host.start();
    host.send({dev, 1'b0}, k);
    host.send(p, k);
    host.start();
    host.send({dev, 1'b1}, k);
    check1(k, 1'b1, "read address ack");
    host.recv(v, 1'b1);
    host.stop();
    check8(v, exp, "read back");
  endtask : rd
  task close_out;
    $display("comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // Watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (90000) @(posedge i_clock);
    fail_count++;
    $display("wrong value at %0t: run did not finish", $time);
    close_out();
  end
  initial begin
    logic k;
    logic [7:0] v, a;
    logic [31:0] d;
    i_clock = 1'b0;
    i_rst = 1'b1;
    strap_sel = 2'h0;
    dev = 7'h30;
    seed = 32'hf543d692;
    repeat (3) @(negedge i_clock);
    i_rst = 1'b0;
    host.hold(4);
    // Power-up defaults
    rd(8'h00, 8'h00);
    rd(8'h6e, 8'h00);
    check1(shdn_n, 1'b0, "shutdown default");
    $display("test defaults done");
    // Every strap connection; a foreign address must be ignored
    for (int s = 0; s < 4; s++) begin
      strap_sel = 2'(s);
      dev = {5'h0c, strap_bits(2'(s))};
      host.hold(20);
      host.start();
      host.send({~dev[6], dev[5:0], 1'b0}, k);
      check1(k, 1'b0, "foreign address");
      host.stop(); // Controller gives up on no acknowledge
      v = 8'($random(seed));
      wr(8'h6e, 1, {v, 24'h0});
      check8(cur_g, v, "green level");
    end
    $display("test address strap done");
    // Burst across the current and phase registers
    d = 32'($random(seed));
    wr(8'h6e, 4, d);
    check8(cur_g, d[31:24], "green");
    check8(cur_r, d[23:16], "red");
    check8(cur_b, d[15:8], "blue");
    check8(phase, d[7:0], "phase");
    rd(8'h71, d[7:0]);
    rd(8'h70, d[15:8]);
    // Burst over the fast/slow duty boundary
    v = 8'($random(seed));
    wr(8'h48, 2, {8'h04, v, 16'h0});
    rd(8'h48, 8'h04);
    rd(8'h49, v);
    $display("test burst done");
    // Random duty bytes written and read back
    for (int i = 0; i < 8; i++) begin
      a = 8'h01 + 8'($unsigned($random(seed)) % 108);
      v = 8'($random(seed));
      if (a <= 8'h48 && !a[0]) v = v & 8'h0c; // Ext bits zero
      wr(a, 1, {v, 24'h0});
      rd(a, v);
    end
    $display("test random duty done");
    // Control register: running, random rate and resolution
    v = (8'($random(seed)) & 8'h32) | 8'h01;
    wr(8'h00, 1, {v, 24'h0});
    rd(8'h00, v);
    check1(shdn_n, 1'b1, "running");
    // Always-on mode stays pending until the update register
    wr(8'h02, 1, {8'h08, 24'h0});
    host.hold(20);
    check1(led[0], 1'b0, "pending only");
    wr(8'h6d, 1, 32'h0);
    host.hold(20);
    check1(led[0], 1'b1, "always on");
    wr(8'h02, 1, {8'h0c, 24'h0});
    wr(8'h6d, 1, 32'h0);
    host.hold(20);
    check1(led[0], 1'b0, "channel off");
    // Grouping: one duty pair drives a whole triple
    wr(8'h00, 1, {8'h41, 24'h0});
    wr(8'h02, 1, {8'h08, 24'h0});
    wr(8'h6d, 1, 32'h0);
    host.hold(20);
    check8({5'h0, led[2:0]}, 8'h07, "triple on");
    $display("test outputs done");
    // Restore defaults through the reset register
    wr(8'h7f, 1, 32'h0);
    host.hold(4);
    check8(cur_r, 8'h00, "red restored");
    check1(shdn_n, 1'b0, "shutdown restored");
    rd(8'h48, 8'h00);
    rd(8'h71, 8'h00);
    $display("test restore done");
    // Reset mid-run: registers back to defaults, bus usable at once
    wr(8'h6f, 1, {8'h5a, 24'h0});
    check8(cur_r, 8'h5a, "red before reset");
    i_rst = 1'b1;
    host.hold(3);
    i_rst = 1'b0;
    host.hold(4);
    check8(cur_r, 8'h00, "red after reset");
    rd(8'h6f, 8'h00);
    $display("test mid reset done");
    close_out();
  end
endmodule : test_led_driver_i2c_register_pwm_ctrl
